// *** power_mode_wake_controller.sv ***
// System mode sequencer with wake latching and fail-safe sleep.
// Assumes synchronous inputs, single-cycle bus strobes, clk_i always on.
`timescale 1ns/1ps
module power_mode_wake_controller #(
   parameter int GPIO_N         = pmw_pkg::GPIO_N_DEF,
   parameter int TICK_DIV       = pmw_pkg::TICK_DIV_DEF,
   parameter int FAILSAFE_TICKS = pmw_pkg::FAILSAFE_TICKS_DEF
) (
   input  wire logic                       clk_i,
   input  wire logic                       resetn_i,
   input  wire logic [pmw_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [pmw_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [pmw_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                       lin_wake_i,
   input  wire logic                       mon_i,
   input  wire logic [GPIO_N-1:0]          gpio_i,
   input  wire logic                       core_stable_i,
   input  wire logic                       wdt_fail_i,
   input  wire logic                       wdt_serviced_i,
   input  wire logic                       supply_fail_i,
   output logic                            reg_en_o,
   output logic                            module_init_o,
   output logic                            pll_disable_o,
   output logic                            core_retention_o,
   output logic                            mcu_slow_clk_o,
   output logic                            lin_avail_o,
   output logic                            lowside_avail_o,
   output logic      [2:0]                 mode_o,
   output logic                            irq_o
);
   import pmw_pkg::*;

   if (GPIO_N < 1 || GPIO_N > GPIO_N_MAX) begin : g_bad_gpio
      $error("GPIO_N out of range");
   end
   if (FAILSAFE_TICKS < 1 || FAILSAFE_TICKS >= 2**CNT_W) begin : g_bad_fs
      $error("FAILSAFE_TICKS does not fit the timer");
   end

   mode_type          state_reg, state_next;
   logic              cyc_en_reg, slow_reg, failsafe_reg;
   logic [2:0]        sel_reg;
   logic              lin_en_reg, mon_en_reg;
   logic [1:0]        edge_reg;
   logic [GPIO_N-1:0] gpio_en_reg, gpio_prev_reg;
   logic              mon_prev_reg;
   logic [3:0]        flag_reg, flag_next;
   logic [2:0]        ists_reg, ists_next, imsk_reg;
   logic [2:0]        wdt_cnt_reg, sup_cnt_reg;
   logic [31:0]       ret0_reg, ret1_reg;

   // Address decode and software access window
   logic sel_mode, sel_wcfg, sel_flag, sel_ists, sel_imsk;
   logic sel_ret0, sel_ret1, sel_stat, sw_ok;
   assign sel_mode = addr_i == OFS_MODE;
   assign sel_wcfg = addr_i == OFS_WCFG;
   assign sel_flag = addr_i == OFS_FLAG;
   assign sel_ists = addr_i == OFS_ISTS;
   assign sel_imsk = addr_i == OFS_IMSK;
   assign sel_stat = addr_i == OFS_STAT;
   assign sel_ret0 = addr_i == OFS_RET0;
   assign sel_ret1 = addr_i == OFS_RET1;
   assign sw_ok = state_reg == ST_ACTIVE || state_reg == ST_SLOWDOWN;

   // Mode commands: stop bit alone is stop, stop with sleep is sleep
   logic wr_mode, cmd_stop, cmd_sleep;
   assign wr_mode   = wr_i && sel_mode && sw_ok;
   assign cmd_stop  = wr_mode && wdata_i[MODE_STOP_BIT];
   assign cmd_sleep = cmd_stop && wdata_i[MODE_SLEEP_BIT];

   // Wake source detection
   logic in_stop, in_sleep, mon_rise, mon_fall;
   logic lin_evt, mon_evt, gpio_evt, cyc_evt;
   assign in_stop  = state_reg == ST_STOP;
   assign in_sleep = state_reg == ST_SLEEP;
   assign mon_rise = mon_i && !mon_prev_reg;
   assign mon_fall = !mon_i && mon_prev_reg;
   assign lin_evt  = lin_en_reg && lin_wake_i;
   assign mon_evt  = mon_en_reg && ((edge_reg[0] && mon_rise)
                     || (edge_reg[1] && mon_fall));
   assign gpio_evt = |(gpio_i & ~gpio_prev_reg & gpio_en_reg);

   // Whichever source fires first ends the low-power mode
   logic wake_stop, wake_sleep;
   assign wake_stop  = in_stop
                       && (lin_evt || mon_evt || gpio_evt || cyc_evt);
   assign wake_sleep = in_sleep
                       && (lin_evt || mon_evt || cyc_evt);

   // Failure counting; the fifth failure of either kind trips fail-safe
   logic awake, wdt_trip, sup_trip, trip, fail_evt;
   assign awake    = sw_ok || state_reg == ST_RESET;
   assign wdt_trip = awake && wdt_fail_i
                     && wdt_cnt_reg == FAIL_LIMIT - 3'h1;
   assign sup_trip = awake && supply_fail_i
                     && sup_cnt_reg == FAIL_LIMIT - 3'h1;
   assign trip     = wdt_trip || sup_trip;
   assign fail_evt = sw_ok && (wdt_fail_i || supply_fail_i);

   // Cyclic timer load: fail-safe period overrides the software setting
   logic             cyc_run;
   logic [CNT_W-1:0] tmr_load;
   assign cyc_run  = (in_stop || in_sleep) && cyc_en_reg;
   assign tmr_load = failsafe_reg ? CNT_W'(FAILSAFE_TICKS)
                     : CNT_W'(PERIOD_BASE_TICKS) << sel_reg;

   cyclic_wake_timer #(
      .TICK_DIV (TICK_DIV),
      .CNT_W    (CNT_W)
   ) u_timer (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .run_i    (cyc_run),
      .load_i   (tmr_load),
      .expire_o (cyc_evt)
   );

   // Mode sequencing on the controller's own free-running clock
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET: begin
            if (trip)
               state_next = ST_SLEEP;
            else if (core_stable_i)
               state_next = ST_ACTIVE;
         end
         ST_ACTIVE, ST_SLOWDOWN: begin
            if (trip)
               state_next = ST_SLEEP;
            else if (fail_evt)
               state_next = ST_RESET;
            else if (cmd_sleep)
               state_next = ST_SLEEP;
            else if (cmd_stop)
               state_next = ST_STOP;
            else
               state_next = slow_reg ? ST_SLOWDOWN : ST_ACTIVE;
         end
         ST_STOP: begin
            if (wake_stop)
               state_next = ST_ACTIVE;
         end
         ST_SLEEP: begin
            if (wake_sleep)
               state_next = ST_RESET;
         end
         default: state_next = ST_RESET;
      endcase
   end

   // Latched wake sources; a new event beats a same-cycle clear
   logic [3:0] flag_set, flag_clr;
   assign flag_set[FLG_LIN]  = lin_evt && !sw_ok;
   assign flag_set[FLG_MON]  = mon_evt && !sw_ok;
   assign flag_set[FLG_GPIO] = gpio_evt && in_stop;
   assign flag_set[FLG_CYC]  = cyc_evt;
   assign flag_clr  = (wr_i && sel_flag) ? wdata_i[3:0] : 4'h0;
   assign flag_next = (flag_reg & ~flag_clr) | flag_set;

   // Interrupt status is cleared by reading it
   logic [2:0] ists_set;
   assign ists_set  = {wdt_fail_i && awake, trip,
                       wake_stop || wake_sleep};
   assign ists_next = (rd_i && sel_ists ? 3'h0 : ists_reg) | ists_set;

   // State and mode outputs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg        <= ST_RESET;
         reg_en_o         <= 1'b1;
         module_init_o    <= 1'b1;
         pll_disable_o    <= 1'b0;
         core_retention_o <= 1'b0;
         mcu_slow_clk_o   <= 1'b0;
         lin_avail_o      <= 1'b0;
         lowside_avail_o  <= 1'b0;
         mode_o           <= 3'h0;
      end else begin
         state_reg        <= state_next;
         reg_en_o         <= state_next != ST_SLEEP;
         module_init_o    <= state_next == ST_RESET;
         pll_disable_o    <= state_next == ST_STOP;
         core_retention_o <= state_next == ST_STOP;
         mcu_slow_clk_o   <= state_next == ST_SLOWDOWN;
         lin_avail_o      <= state_next == ST_ACTIVE
                             || state_next == ST_SLOWDOWN;
         lowside_avail_o  <= state_next == ST_ACTIVE
                             || state_next == ST_SLOWDOWN;
         mode_o           <= state_next;
      end
   end

   // Failure counters; service wipes the watchdog streak, supply count clears only on trip or reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i || trip) begin
         wdt_cnt_reg <= 3'h0;
         sup_cnt_reg <= 3'h0;
      end else if (awake) begin
         if (wdt_fail_i)
            wdt_cnt_reg <= wdt_cnt_reg + 3'h1;
         else if (wdt_serviced_i)
            wdt_cnt_reg <= 3'h0;
         if (supply_fail_i)
            sup_cnt_reg <= sup_cnt_reg + 3'h1;
      end
   end

   // Mode and wake configuration, with fail-safe override
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cyc_en_reg   <= RST_CYC_EN;
         sel_reg      <= SEL_MAX;
         slow_reg     <= 1'b0;
         failsafe_reg <= 1'b0;
         lin_en_reg   <= 1'b0;
         mon_en_reg   <= RST_MON_EN;
         edge_reg     <= RST_EDGE;
         gpio_en_reg  <= '0;
      end else if (trip) begin
         mon_en_reg   <= 1'b1;
         cyc_en_reg   <= 1'b1;
         failsafe_reg <= 1'b1;
      end else begin
         if (wr_mode) begin
            cyc_en_reg   <= wdata_i[MODE_CYC_BIT];
            sel_reg      <= wdata_i[MODE_SEL_LSB +: 3];
            slow_reg     <= wdata_i[MODE_SLOW_BIT];
            failsafe_reg <= 1'b0;
         end
         if (wr_i && sel_wcfg && sw_ok) begin
            lin_en_reg  <= wdata_i[WCFG_LIN_BIT];
            mon_en_reg  <= wdata_i[WCFG_MON_BIT];
            edge_reg    <= wdata_i[WCFG_EDGE_LSB +: 2];
            gpio_en_reg <= wdata_i[WCFG_GPIO_LSB +: GPIO_N];
         end
      end
   end

   // Flags, interrupts, edge history and retained words; retained
   // words survive sleep since only resetn_i clears them
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         flag_reg      <= 4'h0;
         ists_reg      <= 3'h0;
         imsk_reg      <= 3'h0;
         irq_o         <= 1'b0;
         mon_prev_reg  <= 1'b0;
         gpio_prev_reg <= '0;
         ret0_reg      <= 32'h0;
         ret1_reg      <= 32'h0;
      end else begin
         flag_reg      <= flag_next;
         ists_reg      <= ists_next;
         irq_o         <= |(ists_next & imsk_reg);
         mon_prev_reg  <= mon_i;
         gpio_prev_reg <= gpio_i;
         if (wr_i && sel_imsk)
            imsk_reg <= wdata_i[2:0];
         if (wr_i && sel_ret0 && sw_ok)
            ret0_reg <= wdata_i;
         if (wr_i && sel_ret1 && sw_ok)
            ret1_reg <= wdata_i;
      end
   end

   // Read mux; unmapped offsets read zero
   logic [31:0] rd_mux, wcfg_rd;
   assign wcfg_rd = {{(28 - GPIO_N){1'b0}}, gpio_en_reg, edge_reg,
                     mon_en_reg, lin_en_reg};
   assign rd_mux =
      sel_mode ? {25'h0, slow_reg, sel_reg, cyc_en_reg, 2'h0} :
      sel_wcfg ? wcfg_rd :
      sel_flag ? {28'h0, flag_reg} :
      sel_ists ? {29'h0, ists_reg} :
      sel_imsk ? {29'h0, imsk_reg} :
      sel_stat ? {22'h0, failsafe_reg, sup_cnt_reg, wdt_cnt_reg,
                  state_reg} :
      sel_ret0 ? ret0_reg :
      sel_ret1 ? ret1_reg : 32'h0;

   // Read data stand for exactly one cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         rdata_o <= 32'h0;
      else
         rdata_o <= rd_i ? rd_mux : 32'h0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_wdt_fifth;
      awake && wdt_fail_i && wdt_cnt_reg == 3'h4;
   endsequence
   sequence s_sup_fifth;
      awake && supply_fail_i && sup_cnt_reg == 3'h4;
   endsequence
   sequence s_in_sleep_off;
      state_reg == ST_SLEEP && !reg_en_o && !lin_avail_o;
   endsequence

   AST_RESET_HOLD: assert property (
      state_reg == ST_RESET && !core_stable_i && !trip
      |=> state_reg == ST_RESET && module_init_o)
      else $error("left reset mode without stable core");
   AST_RESET_EXIT: assert property (
      state_reg == ST_RESET && core_stable_i && !trip
      |=> state_reg == ST_ACTIVE && !module_init_o)
      else $error("stable core did not reach active");
   AST_WDT_TRIP: assert property (
      s_wdt_fifth |=> s_in_sleep_off ##1 state_reg == ST_SLEEP)
      else $error("fifth watchdog failure did not force sleep");
   AST_SUP_TRIP: assert property (
      s_sup_fifth |=> s_in_sleep_off)
      else $error("fifth supply failure did not force sleep");
   AST_FS_CFG: assert property (
      trip |=> mon_en_reg && cyc_en_reg
      && tmr_load == CNT_W'(FAILSAFE_TICKS))
      else $error("fail-safe wake setup missing");
   AST_STOP_WAKE: assert property (
      in_stop && gpio_evt |=> state_reg == ST_ACTIVE && reg_en_o)
      else $error("enabled GPIO did not wake stop");
   AST_SLEEP_GPIO: assert property (
      in_sleep && !lin_evt && !mon_evt && !cyc_evt
      |=> s_in_sleep_off)
      else $error("sleep left without a sleep wake source");
   AST_FLAG_KEEP: assert property (
      in_sleep && lin_evt |=> flag_reg[FLG_LIN] [*2])
      else $error("LIN wake flag lost");
   AST_STOP_RET: assert property (
      state_reg == ST_STOP |-> pll_disable_o && core_retention_o
      && reg_en_o)
      else $error("stop outputs wrong");
   AST_MON_RISE: assert property (
      (in_stop || in_sleep) && mon_en_reg && !lin_evt && !cyc_evt
      && !gpio_evt && (edge_reg == EDGE_RISE && $fell(mon_i)
      || edge_reg == EDGE_FALL && $rose(mon_i)) |=> $stable(state_reg))
      else $error("monitor edge of the wrong sense caused a wake");
   AST_SLOW: assert property (
      state_reg == ST_SLOWDOWN |-> mcu_slow_clk_o && lin_avail_o
      && lowside_avail_o)
      else $error("slow-down outputs wrong");
   AST_POR_DEF: assert property (
      $rose(resetn_i) |-> mon_en_reg && cyc_en_reg && sel_reg == SEL_MAX)
      else $error("power-on wake defaults wrong");
   AST_SERVICE: assert property (
      awake && wdt_serviced_i && !wdt_fail_i && !trip
      |=> wdt_cnt_reg == 3'h0)
      else $error("service did not clear failure streak");
endmodule : power_mode_wake_controller

// *** pmw_pkg.sv ***
// Constants, field layout and mode type of the power mode wake controller.
// Assumes one 250 MHz clock; slow rates are enable pulses from a divider.
// What this block does
// - Reset mode: supplies on, init, await core stable
// - Watchdog failing over four times forces sleep
// - Five watchdog or supply failures force sleep
// - Fail-safe sleep: monitor wake, one-second cyclic wake
// - Stop: MCU powered, wake on LIN/monitor/GPIO
// - Sleep: MCU unpowered, wake LIN/monitor/cyclic only
// - Cyclic sleep: regulator off, retained registers kept
// - Wake sources equal; first one starts wake
// - Every wake event latched; software clears flags
// - Power-on reset enables monitor wake by default
// - Power-on reset selects cyclic wake, longest period
// - Stop: PLL clock off, core at retention
// - Monitor wake on rising, falling or both edges
// - Slow-down: reduced clock, LIN and low side usable
// - Controller runs on the one clk_i; slow timing from a tick divider
package pmw_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int GPIO_N_DEF = 8;
   localparam int GPIO_N_MAX = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_WCFG = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_ISTS = 8'h0c;
   localparam logic [7:0] OFS_IMSK = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_RET0 = 8'h18;
   localparam logic [7:0] OFS_RET1 = 8'h1c;
   // Mode control fields
   localparam int MODE_STOP_BIT = 0;
   localparam int MODE_SLEEP_BIT = 1;
   localparam int MODE_CYC_BIT = 2;
   localparam int MODE_SEL_LSB = 3;
   localparam int MODE_SLOW_BIT = 6;
   // Wake configuration fields
   localparam int WCFG_LIN_BIT = 0;
   localparam int WCFG_MON_BIT = 1;
   localparam int WCFG_EDGE_LSB = 2;
   localparam int WCFG_GPIO_LSB = 4;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Wake flag and interrupt bits
   localparam int FLG_LIN = 0;
   localparam int FLG_MON = 1;
   localparam int FLG_GPIO = 2;
   localparam int FLG_CYC = 3;
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_WDT = 2;
   // Reset values after power-on, and the failure limit
   localparam logic [2:0] SEL_MAX = 3'h7;
   localparam logic RST_MON_EN = 1'b1;
   localparam logic RST_CYC_EN = 1'b1;
   localparam logic [1:0] RST_EDGE = EDGE_BOTH;
   localparam logic [2:0] FAIL_LIMIT = 3'h5;
   // Timing: slow oscillator rate and cyclic periods
   localparam int CLK_HZ = 250_000_000;
   localparam int SLOW_HZ = 100_000;
   localparam int TICK_DIV_DEF = CLK_HZ / SLOW_HZ;
   localparam int PERIOD_BASE_MS = 10;
   localparam int PERIOD_BASE_TICKS = PERIOD_BASE_MS * SLOW_HZ / 1000;
   localparam int FAILSAFE_MS = 1000;
   localparam int FAILSAFE_TICKS_DEF = FAILSAFE_MS * SLOW_HZ / 1000;
   localparam int CNT_W = 17;
   typedef enum logic [2:0] {
      ST_RESET, ST_ACTIVE, ST_SLOWDOWN, ST_STOP, ST_SLEEP
   } mode_type;
endpackage : pmw_pkg

// *** cyclic_wake_timer.sv ***
// Cyclic wake timer: slow tick divider and period counter.
// Assumes run_i held while a cyclic low-power mode lasts.
`timescale 1ns/1ps
module cyclic_wake_timer #(
   parameter int TICK_DIV = pmw_pkg::TICK_DIV_DEF,
   parameter int CNT_W    = pmw_pkg::CNT_W
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             run_i,
   input  wire logic [CNT_W-1:0] load_i,
   output logic                  expire_o
);
   localparam int DIV_W = $clog2(TICK_DIV);
   logic [DIV_W-1:0] div_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             tick;
   logic             last;

   if (TICK_DIV < 2) begin : g_bad_div
      $error("TICK_DIV must be at least 2");
   end

   // Slow oscillator stand-in: one enable pulse per slow period
   assign tick = run_i && (div_reg == DIV_W'(TICK_DIV - 1));
   assign last = tick && (cnt_reg >= load_i - CNT_W'(1));

   // Counter restarts whenever the mode is left, so each entry is a
   // full period
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !run_i) begin
         div_reg  <= '0;
         cnt_reg  <= '0;
         expire_o <= 1'b0;
      end else begin
         div_reg  <= tick ? '0 : div_reg + DIV_W'(1);
         cnt_reg  <= last ? '0 : cnt_reg + CNT_W'(tick);
         expire_o <= last;
      end
   end
endmodule : cyclic_wake_timer

// *** wake_source_model.sv ***
// Regulator and wake source model facing the mode controller.
// Assumes bench requests arrive as one-cycle strobes after clk edges.
`timescale 1ns/1ps
module wake_source_model (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       reg_en_i,
   input  wire logic       lin_req_i,
   input  wire logic       mon_flip_i,
   input  wire logic [7:0] gpio_req_i,
   output logic            core_stable_o,
   output logic            lin_wake_o,
   output logic            mon_o,
   output logic      [7:0] gpio_o
);
   logic [1:0] ramp_reg;
   // Core supply needs three cycles to settle; drops at once when off
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !reg_en_i) ramp_reg <= 2'h0;
      else if (ramp_reg != 2'h3) ramp_reg <= ramp_reg + 2'h1;
   end
   assign core_stable_o = (ramp_reg == 2'h3);
   // Wake pins: short pulses, monitor level toggles on request
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lin_wake_o <= 1'b0;
         mon_o      <= 1'b0;
         gpio_o     <= 8'h00;
      end else begin
         lin_wake_o <= lin_req_i;
         mon_o      <= mon_o ^ mon_flip_i;
         gpio_o     <= gpio_req_i;
      end
   end
endmodule : wake_source_model

// *** power_mode_wake_controller_test.sv ***
// Self-checking bench for the power mode wake controller.
// Assumes shortened tick divider and fail-safe period parameters.
`timescale 1ns/1ps
module power_mode_wake_controller_test;
   import pmw_pkg::*;
   localparam int TDIV = 4;
   localparam int FST  = 5;
   logic              clk_i = 1'b0;
   logic              resetn_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [31:0]       wdata_i = 32'h0;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic              wdt_f = 1'b0;
   logic              wdt_s = 1'b0;
   logic              sup_f = 1'b0;
   logic              lin_req = 1'b0;
   logic              mon_flip = 1'b0;
   logic [7:0]        gpio_req = 8'h00;
   logic [31:0]       rdata_o, v, ret;
   logic [7:0]        gpio;
   logic [2:0]        mode_o;
   logic              lin_w, mon, stable, reg_en, init, pll, cret;
   logic              slow, lin_av, ls_av, irq_o;
   int                err_total = 0;
   int                n_checks = 0;
   int                cyc = 0;
   // Clock, plus a cycle ceiling against hangs
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         report_and_stop();
      end
   end
   power_mode_wake_controller #(.TICK_DIV(TDIV), .FAILSAFE_TICKS(FST)) dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .lin_wake_i(lin_w), .mon_i(mon), .gpio_i(gpio),
      .core_stable_i(stable), .wdt_fail_i(wdt_f), .wdt_serviced_i(wdt_s),
      .supply_fail_i(sup_f), .reg_en_o(reg_en), .module_init_o(init),
      .pll_disable_o(pll), .core_retention_o(cret),
      .mcu_slow_clk_o(slow), .lin_avail_o(lin_av),
      .lowside_avail_o(ls_av), .mode_o(mode_o), .irq_o(irq_o));
   wake_source_model far (
      .clk_i(clk_i), .resetn_i(resetn_i), .reg_en_i(reg_en),
      .lin_req_i(lin_req), .mon_flip_i(mon_flip), .gpio_req_i(gpio_req),
      .core_stable_o(stable), .lin_wake_o(lin_w), .mon_o(mon),
      .gpio_o(gpio));
   // Expected register words built from field positions
   function automatic logic [31:0] mword(logic stp, logic slp, logic cy,
                                         logic [2:0] sel, logic slw);
      logic [31:0] w;
      w = 32'h0;
      w[MODE_STOP_BIT] = stp;
      w[MODE_SLEEP_BIT] = slp;
      w[MODE_CYC_BIT] = cy;
      w[MODE_SEL_LSB+:3] = sel;
      w[MODE_SLOW_BIT] = slw;
      return w;
   endfunction : mword
   function automatic logic [31:0] wword(logic ln, logic mn,
                                         logic [1:0] ed, logic [7:0] gp);
      logic [31:0] w;
      w = 32'h0;
      w[WCFG_LIN_BIT] = ln;
      w[WCFG_MON_BIT] = mn;
      w[WCFG_EDGE_LSB+:2] = ed;
      w[WCFG_GPIO_LSB+:8] = gp;
      return w;
   endfunction : wword
   task automatic report_and_stop;
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk
   // Bus cycles: one strobe cycle, read data sampled the cycle after
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   // Bounded wait; lets the launching edge's updates land first
   task automatic wait_mode(input logic [2:0] m, input int n);
      #1;
      for (int i = 0; i < n && mode_o !== m; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk(mode_o, m);
   endtask : wait_mode
   // Wake source strobes: 0 LIN, 1 random GPIO, 2 monitor toggle
   task automatic fire(input int s);
      @(posedge clk_i);
      lin_req <= (s == 0);
      gpio_req <= (s == 1) ? 8'h01 << $urandom_range(7, 0) : 8'h00;
      mon_flip <= (s == 2);
      @(posedge clk_i);
      lin_req <= 1'b0;
      gpio_req <= 8'h00;
      mon_flip <= 1'b0;
   endtask : fire
   task automatic pulse(input int k);
      @(posedge clk_i);
      wdt_f <= (k == 0);
      wdt_s <= (k == 1);
      sup_f <= (k == 2);
      @(posedge clk_i);
      wdt_f <= 1'b0;
      wdt_s <= 1'b0;
      sup_f <= 1'b0;
   endtask : pulse
   // Stop entry, an optional refused monitor edge, then a real wake
   task automatic edge_case(input logic [1:0] ed, input bit refuse);
      wr(OFS_WCFG, wword(1'b0, 1'b1, ed, 8'h00));
      wr(OFS_MODE, mword(1'b1, 1'b0, 1'b0, 3'h0, 1'b0));
      wait_mode(ST_STOP, 4);
      if (refuse) begin
         fire(2);
         repeat (8) @(posedge clk_i);
         chk(mode_o, ST_STOP);
      end
      fire(2);
      wait_mode(ST_ACTIVE, 6);
   endtask : edge_case
   // Main sequence: reset, modes, wakes, interrupts, fail-safe
   initial begin
      void'($urandom(32'h5e26a00b));
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      #1 chk({init, reg_en, mode_o}, {2'b11, 3'(ST_RESET)});
      rd(OFS_WCFG, v);
      chk(v, wword(1'b0, RST_MON_EN, RST_EDGE, 8'h00));
      rd(OFS_MODE, v);
      chk(v, mword(1'b0, 1'b0, RST_CYC_EN, SEL_MAX, 1'b0));
      wait_mode(ST_ACTIVE, 20);
      chk({init, lin_av, ls_av}, 3'b011);
      wr(OFS_FLAG, 32'hf);
      wr(OFS_IMSK, 32'h0);
      wr(OFS_MODE, mword(1'b0, 1'b0, 1'b0, 3'h0, 1'b1));
      wait_mode(ST_SLOWDOWN, 4);
      chk({slow, lin_av, ls_av, reg_en}, 4'hf);
      wr(OFS_MODE, 32'h0);
      wait_mode(ST_ACTIVE, 4);
      ret = $urandom;
      wr(OFS_RET0, ret);
      wr(OFS_RET1, ~ret);
      wr(8'h40, ret);
      rd(8'h40, v);
      chk(v, 32'h0);
      wr(OFS_WCFG, wword(1'b1, 1'b1, EDGE_RISE, 8'hff));
      for (int s = 0; s < 3; s++) begin
         wr(OFS_MODE, mword(1'b1, 1'b0, 1'b0, 3'h0, 1'b0));
         wait_mode(ST_STOP, 4);
         chk({pll, cret, reg_en, lin_av}, 4'he);
         fire(s);
         wait_mode(ST_ACTIVE, 6);
         rd(OFS_FLAG, v);
         chk(v, (s == 0) ? 32'h1 : (s == 1) ? 32'h4 : 32'h2);
         wr(OFS_FLAG, 32'hf);
      end
      edge_case(EDGE_FALL, 1'b0);
      edge_case(EDGE_FALL, 1'b1);
      edge_case(EDGE_BOTH, 1'b0);
      wr(OFS_FLAG, 32'hf);
      wr(OFS_IMSK, 32'h1 << IRQ_WAKE);
      wr(OFS_WCFG, wword(1'b1, 1'b1, EDGE_BOTH, 8'hff));
      wr(OFS_MODE, mword(1'b1, 1'b1, 1'b0, 3'h0, 1'b0));
      wait_mode(ST_SLEEP, 4);
      chk(reg_en, 1'b0);
      fire(1);
      repeat (8) @(posedge clk_i);
      chk(mode_o, ST_SLEEP);
      fire(0);
      wait_mode(ST_RESET, 4);
      wait_mode(ST_ACTIVE, 20);
      rd(OFS_FLAG, v);
      chk(v, 32'h1);
      chk(irq_o, 1'b1);
      rd(OFS_ISTS, v);
      chk(v[IRQ_WAKE], 1'b1);
      repeat (2) @(posedge clk_i);
      #1 chk(irq_o, 1'b0);
      wr(OFS_FLAG, 32'hf);
      wr(OFS_MODE, mword(1'b0, 1'b0, 1'b1, 3'h0, 1'b0));
      wr(OFS_MODE, mword(1'b1, 1'b1, 1'b1, 3'h0, 1'b0));
      wait_mode(ST_SLEEP, 4);
      repeat (1000 * TDIV - 100) @(posedge clk_i);
      chk(mode_o, ST_SLEEP);
      wait_mode(ST_RESET, 200);
      wait_mode(ST_ACTIVE, 20);
      rd(OFS_FLAG, v);
      chk(v, 32'h8);
      rd(OFS_RET0, v);
      chk(v, ret);
      rd(OFS_RET1, v);
      chk(v, ~ret);
      wr(OFS_MODE, mword(1'b0, 1'b0, 1'b1, 3'h0, 1'b0));
      wr(OFS_MODE, mword(1'b1, 1'b0, 1'b1, 3'h0, 1'b0));
      wait_mode(ST_STOP, 4);
      repeat (1000 * TDIV - 100) @(posedge clk_i);
      chk(mode_o, ST_STOP);
      wait_mode(ST_ACTIVE, 200);
      wr(OFS_MODE, mword(1'b1, 1'b0, 1'b1, 3'h0, 1'b0));
      wait_mode(ST_STOP, 4);
      fire(0);
      wait_mode(ST_ACTIVE, 6);
      for (int i = 0; i < 4; i++) begin
         pulse(0);
         wait_mode(ST_ACTIVE, 20);
      end
      rd(OFS_STAT, v);
      chk(v[5:3], 3'h4);
      pulse(1);
      rd(OFS_STAT, v);
      chk(v[5:3], 3'h0);
      for (int i = 0; i < 4; i++) begin
         pulse(0);
         wait_mode(ST_ACTIVE, 20);
      end
      pulse(0);
      wait_mode(ST_SLEEP, 4);
      rd(OFS_STAT, v);
      chk(v[9], 1'b1);
      rd(OFS_WCFG, v);
      chk(v[WCFG_MON_BIT], 1'b1);
      rd(OFS_MODE, v);
      chk(v[MODE_CYC_BIT], 1'b1);
      wait_mode(ST_RESET, FST * TDIV + 20);
      wait_mode(ST_ACTIVE, 20);
      repeat (5) pulse(2);
      wait_mode(ST_SLEEP, 4);
      report_and_stop();
   end
endmodule : power_mode_wake_controller_test
